/* hdl/mpci_pkg.sv */
/*
 package of the motion parameter command interpreter: frame layout,
 instruction and type codes, banks, status codes and state types.
 assumes a single clock domain shared by every user of the package.
*/
// Operation
// - move command type 2 moves axis to stored coordinate named by value.
// - set axis parameter writes value into selected parameter of selected axis.
// - axis parameters live in volatile storage, never sent to non-volatile memory.
// - get axis parameter reads selected parameter of selected axis.
// - program get axis parameter also loads the accumulator.
// - direct get axis parameter answers in reply only, accumulator untouched.
// - good replies carry status 100, read commands return the value read.
// - set global parameter writes value to banks 0, 2 or 3.
// - any bank 0 write is stored to non-volatile memory automatically.
// - get global parameter copies parameter to accumulator, ignores request value.
// - global parameter 66 of bank 0 is the serial bus address.
// - axis parameter 4 is max speed, parameter 1 is actual position.
// - store global parameter writes selected parameter to non-volatile memory.
// - store uses instruction 11, parameter in type, bank in bank field.
// - user variables restored from non-volatile memory at power on or request.
// - frame is address, instruction, type, bank, value msb first, checksum.
package mpci_pkg;
   // ---------------------------------------------------------------
   // frame layout
   // ---------------------------------------------------------------
   localparam logic [3:0] FR_ADDR = 4'h0;
   localparam logic [3:0] FR_INSTR = 4'h1;
   localparam logic [3:0] FR_TYPE = 4'h2;
   localparam logic [3:0] FR_BANK = 4'h3;
   localparam logic [3:0] FR_VAL3 = 4'h4;
   localparam logic [3:0] FR_VAL0 = 4'h7;
   localparam logic [3:0] FR_CSUM = 4'h8;
   // ---------------------------------------------------------------
   // instructions, types, banks, parameters
   // ---------------------------------------------------------------
   localparam logic [7:0] I_MOVE = 8'h04;
   localparam logic [7:0] I_SETAP = 8'h05;
   localparam logic [7:0] I_GETAP = 8'h06;
   localparam logic [7:0] I_SETGP = 8'h09;
   localparam logic [7:0] I_GETGP = 8'h0a;
   localparam logic [7:0] I_STORE = 8'h0b;
   localparam logic [7:0] I_RESTORE = 8'h0c;
   localparam logic [7:0] MV_ABS = 8'h00;
   localparam logic [7:0] MV_REL = 8'h01;
   localparam logic [7:0] MV_STORED_COORDINATE_TYPE = 8'h02;
   localparam logic [7:0] BANK_MOD = 8'h00;
   localparam logic [7:0] BANK_USER = 8'h02;
   localparam logic [7:0] BANK_IRQ = 8'h03;
   localparam logic [7:0] AXIS_MAX = 8'h02;
   localparam logic [7:0] STORED_COORDINATE_TYPE_MAX = 8'h14;
   localparam logic [7:0] AP_ACTPOS = 8'h01;
   localparam logic [7:0] AP_MAXSPD = 8'h04;
   localparam logic [7:0] GP_SERADDR = 8'h42;
   localparam logic [7:0] SERADDR_RST = 8'h01;
   // ---------------------------------------------------------------
   // status codes and register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ST_OK = 8'h64;
   localparam logic [7:0] ST_CSUM = 8'h01;
   localparam logic [7:0] ST_BADCMD = 8'h02;
   localparam logic [7:0] ST_BADTYPE = 8'h03;
   localparam logic [7:0] ST_BADVAL = 8'h04;
   localparam logic [1:0] R_CTRL = 2'h0;
   localparam logic [1:0] R_ACCUM = 2'h1;
   localparam logic [1:0] R_STATUS = 2'h2;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] instr;
      logic [7:0] ptype;
      logic [7:0] bank;
      logic [31:0] value;
   } mpci_cmd_s;
   typedef struct packed {
      logic [3:0] cnt;
      logic [7:0] sum;
      mpci_cmd_s cmd;
      logic addr_ok;
      logic pend;
      logic csum_bad;
      logic from_prg;
      logic standalone;
      logic [7:0] ser_addr;
      logic [31:0] accum;
      logic rep_valid;
      logic [7:0] rep_status;
      logic [31:0] rep_value;
      logic mv_valid;
      logic [1:0] mv_axis;
      logic [31:0] mv_target;
      logic nvm_we;
      logic nvm_rd;
      logic [7:0] nvm_bank;
      logic [7:0] nvm_idx;
      logic [31:0] nvm_data;
      logic [31:0] rdata;
   } mpci_state_s;
endpackage : mpci_pkg

/* hdl/mpci_top.sv */
/*
 command interpreter: receives frames from the host byte stream or
 commands from the stored program, executes parameter and move commands.
 assumes every input except ARST_N is synchronous to CLOCK and that an external
 non-volatile store accepts write pulses and pushes restored words.
*/
`timescale 1ns/100ps
module mpci_top
   import mpci_pkg::*;
(
   input wire logic CLOCK, // 25 MHz clock
   input wire logic ARST_N, // async reset, active low
   input wire logic RX_VALID, // host frame byte strobe
   input wire logic [7:0] RX_BYTE, // host frame byte
   input wire logic PRG_VALID, // program command strobe
   input wire mpci_cmd_s PRG_CMD, // program command
   output logic PRG_READY, // program command taken
   input wire logic [95:0] ACT_POS, // actual positions, axis 0 low
   input wire logic CO_WE, // coordinate store write
   input wire logic [1:0] CO_AXIS, // coordinate axis
   input wire logic [4:0] CO_IDX, // coordinate number
   input wire logic [31:0] CO_DATA, // coordinate value
   input wire logic NVM_PUSH, // restored user variable strobe
   input wire logic [7:0] NVM_PUSH_IDX, // restored variable number
   input wire logic [31:0] NVM_PUSH_DATA, // restored variable value
   output logic NVM_WE, // non-volatile write pulse
   output logic NVM_RD, // restore request pulse
   output logic [7:0] NVM_BANK, // bank of nvm access
   output logic [7:0] NVM_IDX, // parameter of nvm access
   output logic [31:0] NVM_DATA, // nvm write data
   output logic REPLY_VALID, // reply pulse
   output logic [7:0] REPLY_STATUS, // reply status code
   output logic [31:0] REPLY_VALUE, // reply value
   output logic MOVE_VALID, // move start pulse
   output logic [1:0] MOVE_AXIS, // axis to move
   output logic [31:0] MOVE_TARGET, // absolute target position
   input wire logic [1:0] REG_ADDR, // register address
   input wire logic [31:0] REG_WDATA, // register write data
   input wire logic REG_WR, // register write strobe
   input wire logic REG_RD, // register read strobe
   output logic [31:0] REG_RDATA // read data, cycle after strobe
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   // axis parameters are plain volatile memory
   logic [31:0] axis_mem [0:2][0:255];
   logic [31:0] stored_coordinate_type_mem [0:2][0:20];
   logic [31:0] gp_mod [0:255];
   logic [31:0] gp_user [0:255];
   logic [31:0] gp_irq [0:255];
   mpci_state_s st, next_st;
   logic rx_done, take_prg, ok, ap_we, gp_we;
   logic [1:0] axis;
   logic [31:0] rd_val, co_val, pos;
   mpci_cmd_s c;

   // ---------------------------------------------------------------
   // read side of the executed command
   // ---------------------------------------------------------------
   assign c = st.cmd;
   assign axis = c.bank[1:0];
   assign rx_done = RX_VALID && (st.cnt == FR_CSUM);
   // a program command waits for an idle byte collector, so a host
   // frame in flight never has its fields overwritten
   assign PRG_READY = st.standalone && !st.pend && !RX_VALID && (st.cnt == FR_ADDR);
   assign take_prg = PRG_VALID && PRG_READY;
   assign pos = ACT_POS[axis * 32 +: 32];
   assign co_val = stored_coordinate_type_mem[axis][c.value[4:0]];

   // parameter read mux
   always_comb begin
      rd_val = 32'h0;
      if (c.instr == I_GETAP) begin
         if (c.ptype == AP_ACTPOS) begin
            rd_val = pos;
         end else begin
            rd_val = axis_mem[axis][c.ptype];
         end
      end else if (c.bank == BANK_MOD && c.ptype == GP_SERADDR) begin
         rd_val = {24'h0, st.ser_addr};
      end else if (c.bank == BANK_MOD) begin
         rd_val = gp_mod[c.ptype];
      end else if (c.bank == BANK_USER) begin
         rd_val = gp_user[c.ptype];
      end else begin
         rd_val = gp_irq[c.ptype];
      end
   end

   // ---------------------------------------------------------------
   // frame receive and command execution
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.rep_valid = 1'b0;
      next_st.mv_valid = 1'b0;
      next_st.nvm_we = 1'b0;
      next_st.nvm_rd = 1'b0;
      next_st.pend = 1'b0;
      ok = 1'b1;
      ap_we = 1'b0;
      gp_we = 1'b0;
      // byte collector, value msb first, running byte sum
      if (RX_VALID) begin
         next_st.cnt = (st.cnt == FR_CSUM) ? FR_ADDR : st.cnt + 4'h1;
         next_st.sum = st.sum + RX_BYTE;
         case (st.cnt)
            FR_ADDR: begin
               next_st.sum = RX_BYTE;
               next_st.addr_ok = (RX_BYTE == st.ser_addr);
            end
            FR_INSTR: next_st.cmd.instr = RX_BYTE;
            FR_TYPE: next_st.cmd.ptype = RX_BYTE;
            FR_BANK: next_st.cmd.bank = RX_BYTE;
            FR_CSUM: begin
               next_st.pend = st.addr_ok;
               next_st.csum_bad = (RX_BYTE != st.sum);
               next_st.from_prg = 1'b0;
            end
            default: next_st.cmd.value = {st.cmd.value[23:0], RX_BYTE};
         endcase
      end
      if (take_prg) begin
         next_st.cmd = PRG_CMD;
         next_st.pend = 1'b1;
         next_st.csum_bad = 1'b0;
         next_st.from_prg = 1'b1;
      end
      // execute the pending command
      if (st.pend) begin
         next_st.rep_status = ST_OK;
         next_st.rep_value = 32'h0;
         if (st.csum_bad) begin
            ok = 1'b0;
            next_st.rep_status = ST_CSUM;
         end else begin
            case (c.instr)
               I_MOVE: begin
                  next_st.mv_axis = axis;
                  if (c.bank > AXIS_MAX) begin
                     ok = 1'b0;
                     next_st.rep_status = ST_BADVAL;
                  end else if (c.ptype == MV_ABS) begin
                     next_st.mv_target = c.value;
                  end else if (c.ptype == MV_REL) begin
                     next_st.mv_target = pos + c.value;
                  end else if (c.ptype != MV_STORED_COORDINATE_TYPE) begin
                     ok = 1'b0;
                     next_st.rep_status = ST_BADTYPE;
                  end else if (c.value > {24'h0, STORED_COORDINATE_TYPE_MAX}) begin
                     ok = 1'b0;
                     next_st.rep_status = ST_BADVAL;
                  end else begin
                     next_st.mv_target = co_val;
                  end
                  next_st.mv_valid = ok;
               end
               I_SETAP: begin
                  ok = (c.bank <= AXIS_MAX) && (c.ptype != AP_ACTPOS);
                  ap_we = ok;
                  next_st.rep_status = ok ? ST_OK : ST_BADVAL;
               end
               I_GETAP: begin
                  ok = (c.bank <= AXIS_MAX);
                  next_st.rep_status = ok ? ST_OK : ST_BADVAL;
                  next_st.rep_value = rd_val;
                  if (ok && st.from_prg) begin
                     next_st.accum = rd_val;
                  end
               end
               I_SETGP, I_GETGP, I_STORE, I_RESTORE: begin
                  ok = (c.bank == BANK_MOD) || (c.bank == BANK_USER)
                     || (c.bank == BANK_IRQ);
                  next_st.rep_status = ok ? ST_OK : ST_BADVAL;
                  next_st.nvm_bank = c.bank;
                  next_st.nvm_idx = c.ptype;
                  next_st.nvm_data = (c.instr == I_SETGP) ? c.value : rd_val;
                  if (ok && c.instr == I_SETGP) begin
                     gp_we = 1'b1;
                     next_st.nvm_we = (c.bank == BANK_MOD);
                     if (c.bank == BANK_MOD && c.ptype == GP_SERADDR) begin
                        next_st.ser_addr = c.value[7:0];
                     end
                  end
                  if (ok && c.instr == I_GETGP) begin
                     next_st.accum = rd_val;
                     next_st.rep_value = rd_val;
                  end
                  next_st.nvm_we = next_st.nvm_we
                     || (ok && c.instr == I_STORE);
                  next_st.nvm_rd = ok && (c.instr == I_RESTORE);
               end
               default: begin
                  ok = 1'b0;
                  next_st.rep_status = ST_BADCMD;
               end
            endcase
         end
         next_st.rep_valid = !st.from_prg;
      end
      // register port
      if (REG_WR && REG_ADDR == R_CTRL) begin
         next_st.standalone = REG_WDATA[0];
      end
      case (REG_ADDR)
         R_CTRL: next_st.rdata = {31'h0, st.standalone};
         R_ACCUM: next_st.rdata = st.accum;
         R_STATUS: next_st.rdata = {24'h0, st.rep_status};
         default: next_st.rdata = 32'h0;
      endcase
      if (!REG_RD) begin
         next_st.rdata = 32'h0;
      end
   end

   // state register
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         st <= '0;
         st.ser_addr <= SERADDR_RST;
      end else begin
         st <= next_st;
      end
   end

   // memory writes, restore pushes land in user bank
   always_ff @(posedge CLOCK) begin
      if (ap_we) begin
         axis_mem[axis][c.ptype] <= c.value;
      end
      if (CO_WE) begin
         stored_coordinate_type_mem[CO_AXIS][CO_IDX] <= CO_DATA;
      end
      if (gp_we && c.bank == BANK_MOD) begin
         gp_mod[c.ptype] <= c.value;
      end
      if (gp_we && c.bank == BANK_IRQ) begin
         gp_irq[c.ptype] <= c.value;
      end
      if (gp_we && c.bank == BANK_USER) begin
         gp_user[c.ptype] <= c.value;
      end else if (NVM_PUSH) begin
         gp_user[NVM_PUSH_IDX] <= NVM_PUSH_DATA;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign REPLY_VALID = st.rep_valid;
   assign REPLY_STATUS = st.rep_status;
   assign REPLY_VALUE = st.rep_value;
   assign MOVE_VALID = st.mv_valid;
   assign MOVE_AXIS = st.mv_axis;
   assign MOVE_TARGET = st.mv_target;
   assign NVM_WE = st.nvm_we;
   assign NVM_RD = st.nvm_rd;
   assign NVM_BANK = st.nvm_bank;
   assign NVM_IDX = st.nvm_idx;
   assign NVM_DATA = st.nvm_data;
   assign REG_RDATA = st.rdata;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_stored_coordinate_type_move_target: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && ok && c.instr == I_MOVE && c.ptype == MV_STORED_COORDINATE_TYPE
      |=> MOVE_VALID && MOVE_TARGET == $past(co_val))
      else $error("coordinate move target wrong");
   a_setap_no_nvm: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && c.instr == I_SETAP |=> !NVM_WE)
      else $error("axis parameter sent to nvm");
   a_prg_read_accum: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && ok && !st.csum_bad && st.from_prg && c.instr == I_GETAP
      |=> st.accum == $past(rd_val))
      else $error("program read not in accumulator");
   a_direct_read_keep: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && !st.from_prg && c.instr == I_GETAP
      |=> $stable(st.accum) && REPLY_VALID)
      else $error("direct read touched accumulator");
   a_read_reply_ok: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && ok && !st.csum_bad && !st.from_prg && c.instr == I_GETAP
      |=> REPLY_STATUS == ST_OK && REPLY_VALUE == $past(rd_val))
      else $error("read reply wrong");
   a_bank0_autostore: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && ok && !st.csum_bad && c.instr == I_SETGP && c.bank == BANK_MOD
      |=> NVM_WE && NVM_BANK == BANK_MOD && NVM_DATA == $past(c.value))
      else $error("bank 0 write not stored");
   a_global_accum: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && ok && !st.csum_bad && c.instr == I_GETGP
      |=> st.accum == $past(rd_val))
      else $error("global read not in accumulator");
   a_serial_addr: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && ok && !st.csum_bad && c.instr == I_SETGP && c.bank == BANK_MOD
      && c.ptype == GP_SERADDR |=> st.ser_addr == $past(c.value[7:0]))
      else $error("serial address not updated");
   a_store_pulse: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && ok && !st.csum_bad && c.instr == I_STORE
      |=> NVM_WE ##1 !NVM_WE)
      else $error("store pulse missing");
   a_csum_reject: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      rx_done && st.addr_ok && RX_BYTE != st.sum
      |=> ##1 REPLY_VALID && REPLY_STATUS == ST_CSUM && !MOVE_VALID && !NVM_WE)
      else $error("bad checksum accepted");

   // guards on replies, moves and stores

   a_prg_no_reply: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && st.from_prg |=> !REPLY_VALID)
      else $error("program command replied");

   a_actpos_read: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && ok && c.instr == I_GETAP && c.ptype == AP_ACTPOS
      |=> REPLY_VALUE == $past(pos))
      else $error("actual position not returned");

   a_csum_no_write: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && st.csum_bad
      |-> !ap_we && !gp_we && !ok)
      else $error("bad frame changed a parameter");

   a_move_axis: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && ok && c.instr == I_MOVE
      |=> MOVE_VALID && MOVE_AXIS == $past(axis))
      else $error("move on wrong axis");

   a_getgp_reply: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && ok && !st.from_prg && c.instr == I_GETGP
      |=> REPLY_VALID && REPLY_STATUS == ST_OK && REPLY_VALUE == $past(rd_val))
      else $error("global read reply wrong");

   a_store_target: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && ok && c.instr == I_STORE
      |=> NVM_BANK == $past(c.bank) && NVM_IDX == $past(c.ptype))
      else $error("store addressed wrong parameter");

   a_user_no_autostore: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      st.pend && c.instr == I_SETGP && c.bank != BANK_MOD
      |=> !NVM_WE)
      else $error("non bank 0 write stored");
endmodule : mpci_top

/* tb/mpci_host.sv */
/*
 host side model: sends whole command frames on the byte strobe port.
 assumes the caller starts a frame only after the previous one ended.
*/
`timescale 1ns/100ps
module mpci_host (
   input wire logic CLOCK, // bench clock
   output logic RX_VALID, // frame byte strobe
   output logic [7:0] RX_BYTE // frame byte
);
   initial begin
      RX_VALID = 1'b0;
      RX_BYTE = 8'h00;
   end
   // -------------------------------------------------------------
   // frame sender, bad flips bit 0 of the check byte, gap idles between bytes
   // -------------------------------------------------------------
   task automatic send(input logic [7:0] a, i, t, b, input logic [31:0] v,
                       input logic bad, input int get_axis_param_cmd);
      logic [7:0] f [0:8];
      f[0] = a;
      f[1] = i;
      f[2] = t;
      f[3] = b;
      for (int k = 0; k < 4; k++) f[4 + k] = v[31 - 8 * k -: 8];
      f[8] = 8'h00;
      for (int k = 0; k < 8; k++) f[8] = f[8] + f[k];
      f[8] = f[8] ^ {7'h00, bad};
      for (int k = 0; k < 9; k++) begin
         @(posedge CLOCK);
         RX_VALID <= 1'b1;
         RX_BYTE <= f[k];
         repeat (get_axis_param_cmd) begin
            @(posedge CLOCK);
            RX_VALID <= 1'b0;
            RX_BYTE <= ~f[k]; // released line shows no stale byte
         end
      end
      @(posedge CLOCK);
      RX_VALID <= 1'b0;
      RX_BYTE <= ~f[8];
   endtask : send
endmodule : mpci_host

/* tb/testbench.sv */
/*
 self-checking bench of the command interpreter: host frames, program
 commands, register port, coordinate and restore inputs.
 assumes the host model above and the package constants.
*/
`timescale 1ns/100ps
module testbench
   import mpci_pkg::*;
;
   logic CLOCK, ARST_N, RX_VALID, PRG_VALID, PRG_READY, CO_WE, NVM_PUSH;
   logic NVM_WE, NVM_RD, REPLY_VALID, MOVE_VALID, REG_WR, REG_RD, rd_q;
   logic [7:0] RX_BYTE, NVM_PUSH_IDX, NVM_BANK, NVM_IDX, REPLY_STATUS, addr;
   logic [1:0] CO_AXIS, MOVE_AXIS, REG_ADDR;
   logic [4:0] CO_IDX;
   logic [31:0] CO_DATA, NVM_PUSH_DATA, NVM_DATA, REPLY_VALUE, MOVE_TARGET;
   logic [31:0] REG_WDATA, REG_RDATA, seed, r;
   logic [95:0] ACT_POS;
   mpci_cmd_s PRG_CMD;
   logic [40:0] rq [$];
   logic [33:0] mq [$];
   logic [47:0] nq [$];
   logic [31:0] gq [$];
   int failures, check_count;
   mpci_host host (.CLOCK(CLOCK), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE));
   mpci_top dut (.CLOCK(CLOCK), .ARST_N(ARST_N), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE),
      .PRG_VALID(PRG_VALID), .PRG_CMD(PRG_CMD), .PRG_READY(PRG_READY), .ACT_POS(ACT_POS),
      .CO_WE(CO_WE), .CO_AXIS(CO_AXIS), .CO_IDX(CO_IDX), .CO_DATA(CO_DATA),
      .NVM_PUSH(NVM_PUSH), .NVM_PUSH_IDX(NVM_PUSH_IDX), .NVM_PUSH_DATA(NVM_PUSH_DATA),
      .NVM_WE(NVM_WE), .NVM_RD(NVM_RD), .NVM_BANK(NVM_BANK), .NVM_IDX(NVM_IDX),
      .NVM_DATA(NVM_DATA), .REPLY_VALID(REPLY_VALID), .REPLY_STATUS(REPLY_STATUS),
      .REPLY_VALUE(REPLY_VALUE), .MOVE_VALID(MOVE_VALID), .MOVE_AXIS(MOVE_AXIS),
      .MOVE_TARGET(MOVE_TARGET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
   // -------------------------------------------------------------
   // clock, helpers
   // -------------------------------------------------------------
   initial begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic check(input string name, input logic [63:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   // frame with noted reply, care=0 leaves the value unchecked
   task automatic fr(input logic [7:0] i, t, b, input logic [31:0] v,
                     input logic [7:0] st, input logic care, input logic [31:0] ev,
                     input logic bad);
      rq.push_back({care, st, care ? ev : 32'h0});
      host.send(addr, i, t, b, v, bad, int'(xs() & 32'h1));
      repeat (4) @(posedge CLOCK);
   endtask : fr
   task automatic reg_op(input logic wr, input logic [1:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      REG_WR <= wr;
      REG_RD <= ~wr;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLOCK);
      REG_WR <= 1'b0;
      REG_RD <= 1'b0;
      repeat (2) @(posedge CLOCK);
   endtask : reg_op
   task automatic rd(input logic [1:0] a, input logic [31:0] e);
      gq.push_back(e);
      reg_op(1'b0, a, 32'h0);
   endtask : rd
   task automatic prg(input mpci_cmd_s c);
      @(posedge CLOCK);
      PRG_VALID <= 1'b1;
      PRG_CMD <= c;
      for (int k = 0; k < 20; k++) begin
         @(negedge CLOCK);
         if (PRG_READY === 1'b1) break;
      end
      @(posedge CLOCK);
      PRG_VALID <= 1'b0;
      repeat (4) @(posedge CLOCK);
   endtask : prg
   // -------------------------------------------------------------
   // output watcher, oldest note against each result
   // -------------------------------------------------------------
   always @(posedge CLOCK) begin
      if (ARST_N === 1'b1) begin
         if (REPLY_VALID !== 1'b0) begin
            if (rq.size() == 0) check("reply_extra", 64'h1, 64'h0);
            else check("reply", {REPLY_STATUS, rq[0][40] ? REPLY_VALUE : 32'h0},
                       rq[0][39:0]);
            if (rq.size() != 0) void'(rq.pop_front());
         end
         if (MOVE_VALID !== 1'b0) begin
            if (mq.size() == 0) check("move_extra", 64'h1, 64'h0);
            else check("move", {MOVE_AXIS, MOVE_TARGET}, mq.pop_front());
         end
         if (NVM_WE !== 1'b0) begin
            if (nq.size() == 0) check("nvm_extra", 64'h1, 64'h0);
            else check("nvm", {NVM_BANK, NVM_IDX, NVM_DATA}, nq.pop_front());
         end
         if (NVM_RD !== 1'b0) begin
            if (nq.size() == 0) check("rd_extra", 64'h1, 64'h0);
            else check("nvm_rd", {NVM_BANK, NVM_IDX, 32'h0}, nq.pop_front());
         end
         if (rd_q === 1'b1) check("reg", REG_RDATA, gq.pop_front());
      end
      rd_q <= REG_RD;
   end
   initial begin
      #(40 * 20000);
      failures++;
      complete_run();
   end
   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      seed = 32'hd32781dc;
      {ARST_N, PRG_VALID, CO_WE, NVM_PUSH, REG_WR, REG_RD} = 6'h00;
      {PRG_CMD, CO_AXIS, CO_IDX, CO_DATA, NVM_PUSH_IDX, NVM_PUSH_DATA} = '0;
      {REG_ADDR, REG_WDATA} = '0;
      failures = 0;
      check_count = 0;
      addr = SERADDR_RST;
      ACT_POS = {xs(), xs(), xs()};
      repeat (10) @(posedge CLOCK);
      ARST_N <= 1'b1;
      rd(R_CTRL, 32'h0);
      // global read loads accumulator, request value ignored
      fr(I_GETGP, GP_SERADDR, BANK_MOD, xs(), ST_OK, 1, 32'h1, 0);
      rd(R_ACCUM, 32'h1);
      reg_op(1'b1, R_ACCUM, 32'h5a); // read-only place
      fr(I_SETAP, AP_MAXSPD, 8'h00, 32'd51200, ST_OK, 0, 0, 0);
      fr(I_GETAP, AP_MAXSPD, 8'h00, 32'h0, ST_OK, 1, 32'd51200, 0);
      for (int a = 0; a < 3; a++)
         fr(I_GETAP, AP_ACTPOS, 8'(a), 32'h0, ST_OK, 1, ACT_POS[32 * a +: 32], 0);
      fr(I_GETAP, AP_MAXSPD, 8'h03, 32'h0, ST_BADVAL, 0, 0, 0);
      rd(R_ACCUM, 32'h1);
      fr(I_SETAP, AP_MAXSPD, 8'h00, 32'd7, ST_CSUM, 0, 0, 1);
      fr(I_GETAP, AP_MAXSPD, 8'h00, 32'h0, ST_OK, 1, 32'd51200, 0);
      fr(8'h0d, 8'h00, 8'h00, 32'h0, ST_BADCMD, 0, 0, 0);
      $display("test axis parameters done");
      // serial address change, old address then ignored
      nq.push_back({BANK_MOD, GP_SERADDR, 32'h3});
      fr(I_SETGP, GP_SERADDR, BANK_MOD, 32'h3, ST_OK, 0, 0, 0);
      host.send(8'h01, I_GETGP, GP_SERADDR, BANK_MOD, 32'h0, 1'b0, 0);
      repeat (4) @(posedge CLOCK);
      addr = 8'h03;
      fr(I_GETGP, GP_SERADDR, BANK_MOD, 32'h0, ST_OK, 1, 32'h3, 0);
      for (int k = 0; k < 2; k++) begin
         r = xs();
         fr(I_SETGP, 8'h2a, k ? BANK_IRQ : BANK_USER, r, ST_OK, 0, 0, 0);
         fr(I_GETGP, 8'h2a, k ? BANK_IRQ : BANK_USER, 32'h0, ST_OK, 1, r, 0);
      end
      fr(I_SETGP, 8'h2a, 8'h01, 32'h0, ST_BADVAL, 0, 0, 0);
      nq.push_back({BANK_IRQ, 8'h2a, r});
      fr(I_STORE, 8'h2a, BANK_IRQ, 32'h0, ST_OK, 0, 0, 0);
      $display("test global parameters done");
      // restore request, then one push and read back
      nq.push_back({BANK_USER, 8'h07, 32'h0});
      fr(I_RESTORE, 8'h07, BANK_USER, 32'h0, ST_OK, 0, 0, 0);
      r = xs();
      @(posedge CLOCK);
      {NVM_PUSH, NVM_PUSH_IDX, NVM_PUSH_DATA} <= {1'b1, 8'h07, r};
      @(posedge CLOCK);
      NVM_PUSH <= 1'b0;
      fr(I_GETGP, 8'h07, BANK_USER, 32'h0, ST_OK, 1, r, 0);
      // stored coordinates, boundary and refused number
      for (int k = 0; k < 2; k++) begin
         r = xs();
         @(posedge CLOCK);
         {CO_WE, CO_AXIS, CO_IDX, CO_DATA} <= {1'b1, k ? 2'h2 : 2'h1, k ? 5'd20 : 5'd8, r};
         @(posedge CLOCK);
         CO_WE <= 1'b0;
         mq.push_back({k ? 2'h2 : 2'h1, r});
         fr(I_MOVE, MV_STORED_COORDINATE_TYPE, k ? 8'h02 : 8'h01, k ? 32'd20 : 32'd8, ST_OK, 0, 0, 0);
      end
      fr(I_MOVE, MV_STORED_COORDINATE_TYPE, 8'h01, 32'd21, ST_BADVAL, 0, 0, 0);
      // absolute move, value bytes msb first
      mq.push_back({2'h0, 32'd90000});
      fr(I_MOVE, MV_ABS, 8'h00, 32'd90000, ST_OK, 0, 0, 0);
      $display("test coordinate moves done");
      // program reads load the accumulator, no reply
      reg_op(1'b1, R_CTRL, 32'h1);
      rd(R_CTRL, 32'h1);
      prg({I_GETAP, AP_MAXSPD, 8'h00, 32'h0});
      rd(R_ACCUM, 32'd51200);
      reg_op(1'b1, R_CTRL, 32'h0);
      $display("test program mode done");
      repeat (6) @(posedge CLOCK);
      check("left", rq.size() + mq.size() + nq.size() + gq.size(), 0);
      complete_run();
   end
endmodule : testbench
